// *** rtl/sfd_host_end.sv ***
// Purpose: Host end: frames requests onto the link and makes its clock.
// Assumes: HALF_CLKS of at least 2 so read data settles through the synchroniser.
// Notes: Link clock is clk divided by 2*HALF_CLKS, idle low.
`timescale 1ns/10ps
module sfd_host_end #(
    parameter int HALF_CLKS = 4
) (
    input  logic                      clk,
    input  logic                      nrst,
    sfd_link_if.host                  link,
    input  logic                      req_valid,
    output logic                      req_ready,
    input  sfd_pkg::sfd_req_kind_type req_kind,
    input  logic [7:0]                req_op,
    input  logic [15:0]               req_data,
    input  logic [23:0]               req_addr,
    input  logic                      cont_read_possible,
    output logic                      rsp_valid,
    output logic [31:0]               rsp_data,
    output logic                      quad_mode
);
    import sfd_pkg::*;

    localparam logic [7:0] HALF_LAST = 8'(HALF_CLKS - 1);
    localparam logic [7:0] GAP_LAST  = 8'(2 * HALF_CLKS - 1);

    typedef struct packed {
        sfd_host_state_type st;
        logic [7:0]  div;
        logic [6:0]  edge_n;
        logic [6:0]  txe;
        logic [6:0]  rxs;
        logic [6:0]  total;
        logic [31:0] tx;
        logic [31:0] rx;
        logic        sclk;
        logic        cs_n;
        logic        por_n;
        logic        quad;
        logic        wide;
        logic        drive_all;
        logic [7:0]  op;
        logic [1:0]  step;
        logic        qe_shadow;
        logic        has_rx;
        logic        rsp_valid;
        logic [31:0] rsp_data;
        logic [3:0]  io_m;
        logic [3:0]  io_s;
    } sfd_host_type;

    sfd_host_type h;
    sfd_host_type next_h;
    logic [7:0]   d_op;
    logic [1:0]   d_ntx;
    logic [23:0]  d_txd;
    logic         d_dum;
    logic [2:0]   d_nrx;
    logic         d_exit;
    logic         d_go;
    logic         d_wide;
    logic [6:0]   d_txe;
    logic [6:0]   d_rxe;

    assign req_ready = (h.st == HS_IDLE) && (h.step == 2'h0);

    always_comb begin
        next_h = h;
        next_h.io_m = link.io;
        next_h.io_s = h.io_m;
        next_h.rsp_valid = 1'b0;
        d_op = 8'h00;
        d_ntx = 2'h0;
        d_txd = 24'h00_0000;
        d_dum = 1'b0;
        d_nrx = 3'h0;
        d_exit = 1'b0;
        d_go = 1'b0;
        if (h.step == 2'h2) begin
            d_op = CMD_RESET_EN;
            d_go = 1'b1;
        end else if (h.step == 2'h1) begin
            d_op = CMD_RESET;
            d_go = 1'b1;
        end else if (req_valid) begin
            d_go = 1'b1;
            case (req_kind)
                REQ_WRITE_STATUS: begin
                    d_op = CMD_WRITE_STATUS;
                    d_ntx = 2'h2;
                    d_txd = {req_data[7:0], req_data[15:8], 8'h00};
                end
                REQ_READ_STATUS1: begin
                    d_op = CMD_READ_STATUS1;
                    d_nrx = 3'h1;
                end
                REQ_READ_STATUS2: begin
                    d_op = CMD_READ_STATUS2;
                    d_nrx = 3'h1;
                end
                REQ_READ_DISCOVERY: begin
                    d_op = CMD_READ_DISCOVERY;
                    d_ntx = 2'h3;
                    d_txd = req_addr;
                    d_dum = 1'b1;
                    d_nrx = 3'h4;
                end
                REQ_SOFT_RESET: begin
                    if (cont_read_possible) begin
                        d_op = CMD_QUAD_OFF;
                        d_ntx = 2'h3;
                        d_txd = 24'hFF_FFFF;
                        d_exit = 1'b1;
                    end else begin
                        d_op = CMD_RESET_EN;
                    end
                end
                default: begin
                    d_op = req_op;
                    d_go = (req_op != CMD_QUAD_ON) || h.qe_shadow;
                end
            endcase
        end
        d_wide = h.quad | d_exit;
        d_txe = d_wide ? (({5'h00, d_ntx} + 7'h01) << 1) : (({5'h00, d_ntx} + 7'h01) << 3);
        d_rxe = d_wide ? ({4'h0, d_nrx} << 1) : ({4'h0, d_nrx} << 3);
        case (h.st)
            HS_INIT: begin
                next_h.div = h.div + 8'h01;
                if (h.div == HALF_LAST) begin
                    next_h.div = 8'h00;
                    next_h.sclk = ~h.sclk;
                    if (h.sclk) begin
                        next_h.edge_n = h.edge_n + 7'h01;
                        if (h.edge_n == POR_EDGES - 7'h01) begin
                            next_h.por_n = 1'b1;
                        end
                        if (h.edge_n == INIT_EDGES - 7'h01) begin
                            next_h.st = HS_IDLE;
                        end
                    end
                end
            end
            HS_IDLE: begin
                if (req_valid && req_ready && req_kind == REQ_SOFT_RESET) begin
                    next_h.step = cont_read_possible ? 2'h2 : 2'h1;
                end else if (h.step != 2'h0) begin
                    next_h.step = h.step - 2'h1;
                end
                if (req_valid && req_ready && req_kind == REQ_WRITE_STATUS) begin
                    next_h.qe_shadow = req_data[8 + QUAD_EN_BIT];
                end
                if (d_go) begin
                    next_h.st = HS_LOW;
                    next_h.cs_n = 1'b0;
                    next_h.div = 8'h00;
                    next_h.edge_n = 7'h00;
                    next_h.op = d_op;
                    next_h.tx = {d_op, d_txd};
                    next_h.wide = d_wide;
                    next_h.drive_all = d_exit;
                    next_h.txe = d_txe;
                    next_h.rxs = d_txe + (d_dum ? DUMMY_EDGES : 7'h00);
                    next_h.total = d_txe + (d_dum ? DUMMY_EDGES : 7'h00) + d_rxe;
                    next_h.has_rx = (d_nrx != 3'h0);
                    next_h.rx = 32'h0000_0000;
                end
            end
            HS_LOW: begin
                next_h.div = h.div + 8'h01;
                if (h.div == HALF_LAST) begin
                    next_h.div = 8'h00;
                    next_h.sclk = 1'b1;
                    next_h.st = HS_HIGH;
                    if (h.edge_n >= h.rxs) begin
                        next_h.rx = h.wide ? {h.rx[27:0], h.io_s} : {h.rx[30:0], h.io_s[1]};
                    end
                end
            end
            HS_HIGH: begin
                next_h.div = h.div + 8'h01;
                if (h.div == HALF_LAST) begin
                    next_h.div = 8'h00;
                    next_h.sclk = 1'b0;
                    next_h.tx = h.wide ? {h.tx[27:0], 4'h0} : {h.tx[30:0], 1'b0};
                    next_h.edge_n = h.edge_n + 7'h01;
                    next_h.st = HS_LOW;
                    if (h.edge_n == h.total - 7'h01) begin
                        next_h.cs_n = 1'b1;
                        next_h.st = HS_GAP;
                    end
                end
            end
            HS_GAP: begin
                next_h.div = h.div + 8'h01;
                if (h.div == GAP_LAST) begin
                    next_h.div = 8'h00;
                    next_h.st = HS_IDLE;
                    next_h.rsp_valid = h.has_rx;
                    if (h.has_rx) begin
                        next_h.rsp_data = h.rx;
                    end
                    if (h.op == CMD_QUAD_OFF || h.op == CMD_RESET) begin
                        next_h.quad = 1'b0;
                    end else if (h.op == CMD_QUAD_ON) begin
                        next_h.quad = 1'b1;
                    end
                end
            end
            default: begin
                next_h.st = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            h <= '{st: HS_INIT, sclk: 1'b0, cs_n: 1'b1, por_n: 1'b0, default: '0};
        end else begin
            h <= next_h;
        end
    end

    // Outputs are released once the transmit edges are spent, ahead of read data.
    assign link.sclk = h.sclk;
    assign link.cs_n = h.cs_n;
    assign link.por_n = h.por_n;
    assign link.host_io_out = h.drive_all ? 4'hF : (h.wide ? h.tx[31:28] : {3'b111, h.tx[31]});
    assign link.host_io_oe_n = (h.cs_n || h.edge_n >= h.txe) ? 4'hF : (h.wide ? 4'h0 : 4'hE);
    assign rsp_valid = h.rsp_valid;
    assign rsp_data = h.rsp_data;
    assign quad_mode = h.quad;

endmodule : sfd_host_end

// *** common/sfd_pkg.sv ***
// Purpose: Shared constants and types for the flash link ends.
// Assumes: One host end and one flash end joined by sfd_link_if.
// Notes: The discovery doubleword is built from its fields.
package sfd_pkg;

    localparam logic [7:0] CMD_WRITE_EN       = 8'h06;
    localparam logic [7:0] CMD_VOL_WRITE_EN   = 8'h50;
    localparam logic [7:0] CMD_WRITE_STATUS   = 8'h01;
    localparam logic [7:0] CMD_READ_STATUS1   = 8'h05;
    localparam logic [7:0] CMD_READ_STATUS2   = 8'h35;
    localparam logic [7:0] CMD_READ_DISCOVERY = 8'h5A;
    localparam logic [7:0] CMD_RESET_EN       = 8'h66;
    localparam logic [7:0] CMD_RESET          = 8'h99;
    localparam logic [7:0] CMD_QUAD_ON        = 8'h38;
    localparam logic [7:0] CMD_QUAD_OFF       = 8'hFF;

    localparam logic [7:0]  ENTER4B_FIELD    = 8'h80;
    localparam logic [9:0]  EXIT4B_FIELD     = 10'h300;
    localparam logic [5:0]  SOFT_RESET_FIELD = 6'h30;
    localparam logic [0:0]  DW16_SPARE_BIT   = 1'h1;
    localparam logic [6:0]  SR_WRITE_FIELD   = 7'h68;
    localparam logic [31:0] DW16_VALUE       = {ENTER4B_FIELD, EXIT4B_FIELD,
                                                SOFT_RESET_FIELD, DW16_SPARE_BIT,
                                                SR_WRITE_FIELD};
    localparam logic [23:0] DW16_ADDR        = 24'h00_0068;

    localparam int          QUAD_EN_BIT = 1;
    localparam logic [7:0]  SR1_WMASK   = 8'hFC;
    localparam logic [7:0]  SR2_WMASK   = 8'hFF;
    localparam logic [7:0]  SR1_RESET   = 8'h00;
    localparam logic [7:0]  SR2_RESET   = 8'h00;

    localparam logic [2:0]  DUMMY_LAST  = 3'h7;
    localparam logic [6:0]  DUMMY_EDGES = 7'h08;
    localparam logic [6:0]  POR_EDGES   = 7'h08;
    localparam logic [6:0]  INIT_EDGES  = 7'h10;

    typedef enum logic [5:0] {
        PH_CMD   = 6'h01,
        PH_ADDR  = 6'h02,
        PH_DUMMY = 6'h04,
        PH_READ  = 6'h08,
        PH_WRITE = 6'h10,
        PH_SKIP  = 6'h20
    } sfd_phase_type;

    typedef enum logic [1:0] {
        SEL_SR1  = 2'h0,
        SEL_SR2  = 2'h1,
        SEL_DISC = 2'h2
    } sfd_read_sel_type;

    typedef enum logic [4:0] {
        HS_INIT = 5'h01,
        HS_IDLE = 5'h02,
        HS_LOW  = 5'h04,
        HS_HIGH = 5'h08,
        HS_GAP  = 5'h10
    } sfd_host_state_type;

    typedef enum logic [2:0] {
        REQ_OP             = 3'h0,
        REQ_WRITE_STATUS   = 3'h1,
        REQ_READ_STATUS1   = 3'h2,
        REQ_READ_STATUS2   = 3'h3,
        REQ_READ_DISCOVERY = 3'h4,
        REQ_SOFT_RESET     = 3'h5
    } sfd_req_kind_type;

endpackage : sfd_pkg

// *** common/sfd_link_if.sv ***
// Purpose: Serial flash link between host end and flash end.
// Assumes: Lines with no driver are pulled high.
// Notes: The resolved level of each data line is io.
`timescale 1ns/10ps
interface sfd_link_if;
    logic       sclk;
    logic       cs_n;
    logic       por_n;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe_n;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe_n;
    logic [3:0] io;

    assign io = (~host_io_oe_n & host_io_out) | (~dev_io_oe_n & dev_io_out)
              | (host_io_oe_n & dev_io_oe_n);

    modport host (output sclk, output cs_n, output por_n, output host_io_out,
                  output host_io_oe_n, input io);
    modport dev (input sclk, input cs_n, input por_n, input io,
                 output dev_io_out, output dev_io_oe_n);
endinterface : sfd_link_if

// *** rtl/sfd_flash_end.sv ***
// Purpose: Flash end: command decoder, soft reset, status writes, discovery dword.
// Assumes: Mode 0 link; chip select and data lines are timed to the link clock.
// Notes: Frame state clears asynchronously when chip select rises.
`timescale 1ns/10ps
// What this block does
// - Discovery bytes 68h..6Bh return E8h,30h,C0h,80h.
// - Enter-four-byte field reads 10000000b, unsupported.
// - Exit-four-byte field reads 11_0000_0000b, unsupported.
// - Reset only after 66h then 99h.
// - Reset pair taken at current line width.
// - Host ends continuous quad read before reset.
// - Status powers up from stored copy.
// - 06h enables persistent status write.
// - 50h enables volatile-only status write.
// - Quad enable set, then 38h, four lines.
// - Quad enable bit one of second status.
module sfd_flash_end #(
    parameter logic [7:0] SR1_POWERUP = sfd_pkg::SR1_RESET,
    parameter logic [7:0] SR2_POWERUP = sfd_pkg::SR2_RESET
) (
    sfd_link_if.dev    link,
    output logic [7:0] status1,
    output logic [7:0] second_status_register,
    output logic       quad_lines_enable,
    output logic       pins_protect_active,
    output logic       quad_mode,
    output logic [7:0] reset_count
);
    import sfd_pkg::*;

    typedef struct packed {
        logic [7:0] sr1_nv;
        logic [7:0] sr2_nv;
        logic [7:0] sr1;
        logic [7:0] sr2;
        logic       wel;
        logic       vwel;
        logic       rst_en;
        logic       quad;
        logic [7:0] resets;
    } sfd_keep_type;

    typedef struct packed {
        sfd_phase_type    phase;
        logic [2:0]       cnt;
        logic [7:0]       shin;
        logic [23:0]      addr;
        logic [1:0]       nbyte;
        logic [7:0]       osh;
        sfd_read_sel_type sel;
        logic             to_nv;
    } sfd_frame_type;

    localparam sfd_frame_type FRAME_IDLE = '{phase: PH_CMD, sel: SEL_SR1, default: '0};

    sfd_keep_type  k;
    sfd_keep_type  next_k;
    sfd_frame_type f;
    sfd_frame_type next_f;
    logic [1:0]    por_pipe;
    logic          por_ok;
    logic [7:0]    shifted;
    logic          last;
    logic [7:0]    sr1_view;

    // The table is a constant, so no status or mode bit can alter it.
    function automatic logic [7:0] discovery_byte(input logic [23:0] a);
        logic [7:0] b;
        b = 8'h00;
        if (a[23:2] == DW16_ADDR[23:2]) begin
            b = DW16_VALUE[{a[1:0], 3'b000} +: 8];
        end
        return b;
    endfunction : discovery_byte

    // Power-on reset arrives from the host domain and is resynchronised here.
    always_ff @(posedge link.sclk) begin
        por_pipe <= {por_pipe[0], link.por_n};
    end
    assign por_ok = por_pipe[1];

    always_comb begin
        next_k = k;
        next_f = f;
        sr1_view = {k.sr1[7:2], k.wel, 1'b0};
        shifted = k.quad ? {f.shin[3:0], link.io} : {f.shin[6:0], link.io[0]};
        last = k.quad ? (f.cnt == 3'h1) : (f.cnt == 3'h7);
        next_f.cnt = last ? 3'h0 : f.cnt + 3'h1;
        next_f.shin = shifted;
        case (f.phase)
            PH_CMD: begin
                if (last) begin
                    next_f.phase = PH_SKIP;
                    next_k.rst_en = 1'b0;
                    case (shifted)
                        CMD_RESET_EN: begin
                            next_k.rst_en = 1'b1;
                        end
                        CMD_RESET: begin
                            if (k.rst_en) begin
                                next_k.sr1 = k.sr1_nv;
                                next_k.sr2 = k.sr2_nv;
                                next_k.wel = 1'b0;
                                next_k.vwel = 1'b0;
                                next_k.quad = 1'b0;
                                next_k.resets = k.resets + 8'h01;
                            end
                        end
                        CMD_WRITE_EN: begin
                            next_k.wel = 1'b1;
                            next_k.vwel = 1'b0;
                        end
                        CMD_VOL_WRITE_EN: begin
                            next_k.vwel = 1'b1;
                            next_k.wel = 1'b0;
                        end
                        CMD_WRITE_STATUS: begin
                            if (k.wel || k.vwel) begin
                                next_f.phase = PH_WRITE;
                                next_f.to_nv = k.wel;
                                next_f.nbyte = 2'h0;
                                next_k.wel = 1'b0;
                                next_k.vwel = 1'b0;
                            end
                        end
                        CMD_READ_STATUS1: begin
                            next_f.phase = PH_READ;
                            next_f.sel = SEL_SR1;
                            next_f.osh = sr1_view;
                        end
                        CMD_READ_STATUS2: begin
                            next_f.phase = PH_READ;
                            next_f.sel = SEL_SR2;
                            next_f.osh = k.sr2;
                        end
                        CMD_READ_DISCOVERY: begin
                            next_f.phase = PH_ADDR;
                            next_f.nbyte = 2'h0;
                        end
                        CMD_QUAD_ON: begin
                            if (k.sr2[QUAD_EN_BIT]) begin
                                next_k.quad = 1'b1;
                            end
                        end
                        CMD_QUAD_OFF: begin
                            next_k.quad = 1'b0;
                        end
                        default: begin
                            next_f.phase = PH_SKIP;
                        end
                    endcase
                end
            end
            PH_ADDR: begin
                if (last) begin
                    next_f.addr = {f.addr[15:0], shifted};
                    next_f.nbyte = f.nbyte + 2'h1;
                    if (f.nbyte == 2'h2) begin
                        next_f.phase = PH_DUMMY;
                        next_f.nbyte = 2'h0;
                    end
                end
            end
            PH_DUMMY: begin
                // Dummy length is counted in clocks, whatever the line width.
                next_f.cnt = f.cnt + 3'h1;
                if (f.cnt == DUMMY_LAST) begin
                    next_f.phase = PH_READ;
                    next_f.sel = SEL_DISC;
                    next_f.osh = discovery_byte(f.addr);
                end
            end
            PH_READ: begin
                if (last) begin
                    case (f.sel)
                        SEL_SR1: next_f.osh = sr1_view;
                        SEL_SR2: next_f.osh = k.sr2;
                        default: begin
                            next_f.addr = f.addr + 24'h00_0001;
                            next_f.osh = discovery_byte(f.addr + 24'h00_0001);
                        end
                    endcase
                end else begin
                    next_f.osh = k.quad ? {f.osh[3:0], 4'h0} : {f.osh[6:0], 1'b0};
                end
            end
            PH_WRITE: begin
                if (last) begin
                    next_f.nbyte = f.nbyte + 2'h1;
                    if (f.nbyte == 2'h0) begin
                        next_k.sr1 = (k.sr1 & ~SR1_WMASK) | (shifted & SR1_WMASK);
                        if (f.to_nv) begin
                            next_k.sr1_nv = (k.sr1_nv & ~SR1_WMASK) | (shifted & SR1_WMASK);
                        end
                    end else begin
                        next_f.phase = PH_SKIP;
                        next_k.sr2 = (k.sr2 & ~SR2_WMASK) | (shifted & SR2_WMASK);
                        if (f.to_nv) begin
                            next_k.sr2_nv = (k.sr2_nv & ~SR2_WMASK) | (shifted & SR2_WMASK);
                        end
                    end
                end
            end
            default: begin
                next_f.phase = PH_SKIP;
            end
        endcase
    end

    always_ff @(posedge link.sclk) begin
        if (!por_ok) begin
            k <= '{sr1_nv: SR1_POWERUP, sr2_nv: SR2_POWERUP, sr1: SR1_POWERUP,
                   sr2: SR2_POWERUP, default: '0};
        end else if (!link.cs_n) begin
            k <= next_k;
        end
    end

    // The link clock stops between frames, so chip select ends the frame itself.
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            f <= FRAME_IDLE;
        end else if (!por_ok) begin
            f <= FRAME_IDLE;
        end else begin
            f <= next_f;
        end
    end

    assign link.dev_io_out = k.quad ? f.osh[7:4] : {2'b00, f.osh[7], 1'b0};
    assign link.dev_io_oe_n = (f.phase != PH_READ) ? 4'hF : (k.quad ? 4'h0 : 4'hD);
    assign status1 = k.sr1;
    assign second_status_register = k.sr2;
    assign quad_lines_enable = k.sr2[QUAD_EN_BIT];
    assign pins_protect_active = ~k.sr2[QUAD_EN_BIT];
    assign quad_mode = k.quad;
    assign reset_count = k.resets;

endmodule : sfd_flash_end

// *** verif/sfd_link_checker.sv ***
// Purpose: Wire-level checks on the flash link.
// Assumes: Mode 0 link, clock idle low.
// Notes: Edge count clears when chip select rises.
`timescale 1ns/10ps
module sfd_link_checker (
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       por_n,
    input wire logic [3:0] host_io_out,
    input wire logic [3:0] host_io_oe_n,
    input wire logic [3:0] dev_io_out,
    input wire logic [3:0] dev_io_oe_n,
    input wire logic [3:0] io
);
    logic [7:0] edges;
    // Cleared by chip select itself, since the link clock stands still between frames.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n)
            edges <= 8'h00;
        else if (edges != 8'hFF)
            edges <= edges + 8'h01;
    end
    default clocking cb @(posedge sclk); endclocking
    default disable iff (!por_n);
    a_lanes_no_clash: assert property ((host_io_oe_n | dev_io_oe_n) == 4'hF)
        else $error("Both ends drive one lane.");
    a_dev_quiet_idle: assert property (cs_n |-> dev_io_oe_n == 4'hF)
        else $error("Flash drives outside a frame.");
    a_lanes_idle_high: assert property (cs_n |-> io == 4'hF)
        else $error("A lane is held off its idle level outside a frame.");
    a_dev_quiet_cmd: assert property (!cs_n && edges < 8'h02 |-> dev_io_oe_n == 4'hF)
        else $error("Flash drives during the instruction.");
    a_host_drives_cmd: assert property (!cs_n && edges < 8'h02 |-> !host_io_oe_n[0])
        else $error("Host leaves lane 0 during the instruction.");
    a_dev_lane_sets: assert property (dev_io_oe_n inside {4'hF, 4'hD, 4'h0})
        else $error("Flash drives an odd lane set.");
    a_host_lane_sets: assert property (host_io_oe_n inside {4'hF, 4'hE, 4'h0})
        else $error("Host drives an odd lane set.");
    a_single_read_late: assert property (dev_io_oe_n == 4'hD |-> edges >= 8'h08)
        else $error("Single-line answer before the instruction ends.");
    a_por_then_idle: assert property ($rose(por_n) |-> cs_n [*4])
        else $error("Frame starts too soon after power-on.");
    cover property (!cs_n && dev_io_oe_n == 4'h0);
    cover property (dev_io_oe_n == 4'hD);
    cover property ($rose(por_n));
endmodule : sfd_link_checker

// *** verif/sfd_dword16_reset_srwe_tb.sv ***
// Purpose: Drives requests through the host end into the flash end and checks answers.
// Assumes: HALF_CLKS of 4, so the host makes a link clock of clk/8.
// Notes: The host makes the link clock, so the bench makes none.
`timescale 1ns/10ps
module sfd_dword16_reset_srwe_tb;
    import sfd_pkg::*;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic             req_valid = 1'b0;
    logic             req_ready;
    sfd_req_kind_type req_kind = REQ_OP;
    logic [7:0]       req_op = 8'h00;
    logic [15:0]      req_data = 16'h0000;
    logic [23:0]      req_addr = 24'h00_0000;
    logic             cont_read_possible = 1'b0;
    logic             rsp_valid;
    logic [31:0]      rsp_data;
    logic             host_quad;
    logic             quad_lines_enable;
    logic             pins_protect_active;
    logic             quad_mode;
    logic [7:0]       reset_count;
    logic [7:0]       status1;
    logic [7:0]       second_status_register;
    int               miscompares = 0;
    int               compares = 0;
    int               cycles = 0;
    always #25 clk = ~clk;
    sfd_link_if link ();
    sfd_host_end #(.HALF_CLKS(4)) sfd_host_end_i (.clk(clk), .nrst(nrst), .link(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_op(req_op),
        .req_data(req_data), .req_addr(req_addr), .cont_read_possible(cont_read_possible),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .quad_mode(host_quad));
    sfd_flash_end sfd_flash_end_i (.link(link), .status1(status1),
        .second_status_register(second_status_register),
        .quad_lines_enable(quad_lines_enable), .pins_protect_active(pins_protect_active),
        .quad_mode(quad_mode), .reset_count(reset_count));
    sfd_link_checker sfd_link_checker_i (.sclk(link.sclk), .cs_n(link.cs_n), .por_n(link.por_n),
        .host_io_out(link.host_io_out), .host_io_oe_n(link.host_io_oe_n),
        .dev_io_out(link.dev_io_out), .dev_io_oe_n(link.dev_io_oe_n), .io(link.io));
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle_wait();
        do @(posedge clk) #1; while (req_ready !== 1'b1);
    endtask : idle_wait
    task automatic send(input sfd_req_kind_type k, input logic [7:0] op, input logic [15:0] d);
        idle_wait();
        req_kind = k;
        req_op = op;
        req_data = d;
        req_valid = 1'b1;
        @(posedge clk) #1;
        req_valid = 1'b0;
    endtask : send
    task automatic rd(input sfd_req_kind_type k, input logic [23:0] a, input logic [31:0] exp);
        req_addr = a;
        send(k, 8'h00, 16'h0000);
        while (rsp_valid !== 1'b1) @(posedge clk) #1;
        chk(rsp_data, exp);
    endtask : rd
    // About 25 frames of under 700 cycles each; the ceiling leaves 1.7 times that.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clk) #1;
        nrst = 1'b1;
        rd(REQ_READ_DISCOVERY, 24'h00_0068, 32'hE830_C080);
        rd(REQ_READ_DISCOVERY, 24'h00_0069, 32'h30C0_8000);
        rd(REQ_READ_STATUS1, 24'h00_0000, 32'h0000_0000);
        send(REQ_WRITE_STATUS, 8'h00, 16'h02FC);
        rd(REQ_READ_STATUS2, 24'h00_0000, 32'h0000_0000);
        send(REQ_OP, CMD_WRITE_EN, 16'h0000);
        send(REQ_WRITE_STATUS, 8'h00, 16'h02FC);
        rd(REQ_READ_STATUS1, 24'h00_0000, 32'h0000_00FC);
        chk({16'h0, status1, second_status_register}, 32'h0000_FC02);
        chk({30'h0, quad_lines_enable, pins_protect_active}, 32'h0000_0002);
        send(REQ_OP, CMD_VOL_WRITE_EN, 16'h0000);
        send(REQ_WRITE_STATUS, 8'h00, 16'h020C);
        rd(REQ_READ_STATUS1, 24'h00_0000, 32'h0000_000C);
        send(REQ_SOFT_RESET, 8'h00, 16'h0000);
        rd(REQ_READ_STATUS1, 24'h00_0000, 32'h0000_00FC);
        chk({24'h0, reset_count}, 32'h0000_0001);
        // A cancelled enable must leave the count where it was.
        send(REQ_OP, CMD_RESET_EN, 16'h0000);
        send(REQ_OP, CMD_WRITE_EN, 16'h0000);
        send(REQ_OP, CMD_RESET, 16'h0000);
        send(REQ_OP, CMD_QUAD_ON, 16'h0000);
        idle_wait();
        chk({22'h0, host_quad, quad_mode, reset_count}, 32'h0000_0301);
        rd(REQ_READ_DISCOVERY, 24'h00_0068, 32'hE830_C080);
        // The reset pair now goes out on four lanes, since quad mode is still on.
        send(REQ_SOFT_RESET, 8'h00, 16'h0000);
        idle_wait();
        chk({22'h0, host_quad, quad_mode, reset_count}, 32'h0000_0002);
        send(REQ_OP, CMD_QUAD_ON, 16'h0000);
        cont_read_possible = 1'b1;
        send(REQ_SOFT_RESET, 8'h00, 16'h0000);
        idle_wait();
        chk({22'h0, host_quad, quad_mode, reset_count}, 32'h0000_0003);
        results();
    end
endmodule : sfd_dword16_reset_srwe_tb
